// file: testbench/crf_core_regs_asserts.sv
// port assertions for the core register file
`timescale 1ns/1ps
module crf_core_regs_asserts (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // watched requests
  input wire logic flag_we,
  input wire logic flag_val,
  input wire logic write_ctrl_op,
  input wire logic read_ctrl_op,
  input wire logic [2:0] ctrl_num,
  input wire logic exception_event,
  input wire logic return_from_exception,
  input wire logic external_request,
  input wire crf_pkg::crf_sum_op_t sum_op,
  // watched answers
  input wire crf_pkg::crf_status_t status_word,
  input wire logic [31:0] flag_mirror,
  input wire logic ctrl_rvalid,
  input wire logic [31:0] resume_pc,
  input wire logic resume_valid,
  input wire logic ext_int_take,
  input wire logic [31:0] sum_rdata,
  input wire logic sum_rvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // live select, gate, flag and their backups
  wire [2:0] live_w = {status_word.pointer_select,
    status_word.interrupt_gate, status_word.flag};
  wire [2:0] saved_w = {status_word.saved_pointer_select,
    status_word.saved_int_gate, status_word.saved_flag};
  wire ret_w = ce && return_from_exception && !exception_event;

  AST_RST_CLEAR: assert property (disable iff (1'b0)
    !rstn && ce |=> (status_word & 32'hFFFF3EFF) == 32'h00000000)
    else $error("status not cleared by reset");
  AST_RSV_ZERO: assert property (
    (status_word & 32'hFFFF3E3E) == 32'h00000000)
    else $error("reserved status bit set");
  AST_MIRROR: assert property (
    flag_mirror == {31'h00000000, status_word.flag})
    else $error("mirror differs from flag");
  AST_EXC_SAVE: assert property (
    ce && exception_event |=> saved_w == $past(live_w)
      && live_w[2:1] == 2'h0)
    else $error("entry did not save state");
  AST_RET_RESTORE: assert property (
    ret_w |=> live_w == $past(saved_w))
    else $error("return did not restore state");
  AST_RESUME: assert property (
    ret_w |-> ##[1:2] resume_valid && resume_pc[1:0] == 2'h0)
    else $error("resume missing or unaligned");
  AST_GATE: assert property (
    ce |=> ext_int_take == ($past(external_request)
      && $past(status_word.interrupt_gate)))
    else $error("interrupt gating wrong");
  AST_CTRL_RVALID: assert property (
    ce && read_ctrl_op |-> ##2 ctrl_rvalid)
    else $error("control read not answered");
  AST_SUM_SIGN: assert property (
    ce && sum_op.sum_read_upper |-> ##[1:2] sum_rvalid
      && sum_rdata[31:24] == {8{sum_rdata[23]}})
    else $error("upper sum read not sign filled");
  AST_FLAG: assert property (
    ce && flag_we && !exception_event && !return_from_exception
      && !(write_ctrl_op && ctrl_num == 3'h0)
      |=> status_word.flag == $past(flag_val))
    else $error("flag not updated");
endmodule : crf_core_regs_asserts

bind crf_core_regs crf_core_regs_asserts chk_u (.*);

// file: testbench/crf_core_regs_tb.sv
// self-checking bench for the core register file
`timescale 1ns/1ps
module crf_core_regs_tb;
  logic clk, rstn, ce, wr_en, call_en, write_ctrl_op, read_ctrl_op;
  logic exception_event, return_from_exception, external_request;
  logic flag_we, flag_val, ctrl_rvalid, resume_valid, ext_int_take;
  logic sum_rvalid, dsp_load_en, product_op;
  logic [3:0] rd_a_addr, rd_b_addr, wr_addr;
  logic [2:0] ctrl_num;
  logic [31:0] rd_a_data, rd_b_data, wr_data, call_ret_addr, ctrl_wdata;
  logic [31:0] ctrl_rdata, exc_pc, resume_pc, sum_wdata, sum_rdata;
  logic [31:0] flag_mirror;
  logic [55:0] dsp_load_val;
  crf_pkg::crf_sum_op_t sum_op;
  crf_pkg::crf_status_t status_word;
  int num_errors = 0;
  int total_checks = 0;

  crf_core_regs dut_u (.*);
  crf_exec_model pm_u (.*);

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic summarize;
    if (num_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // 0 control, 1 sum, 2 resume answer; bounded wait
  task automatic wait_hi(input int s);
    for (int i = 0; i < 8; i++)
    begin
      if ((s == 0 ? ctrl_rvalid : s == 1 ? sum_rvalid : resume_valid) === 1)
        return;
      @(negedge clk);
    end
    num_errors++;
    $display("CHECK FAILED %0t no answer", $time);
    summarize();
  endtask : wait_hi

  task automatic ctrl_wr(input logic [2:0] n, input logic [31:0] d);
    {write_ctrl_op, ctrl_num, ctrl_wdata} = {1'b1, n, d};
    @(negedge clk);
    write_ctrl_op = 1'b0;
  endtask : ctrl_wr

  task automatic ctrl_rd(input logic [2:0] n, input logic [31:0] exp);
    {read_ctrl_op, ctrl_num} = {1'b1, n};
    @(negedge clk);
    read_ctrl_op = 1'b0;
    wait_hi(0);
    check(ctrl_rdata, exp);
  endtask : ctrl_rd

  task automatic gpr_wr(input logic [3:0] a, input logic [31:0] d);
    {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask : gpr_wr

  task automatic gpr_rd(input logic [3:0] a, input logic [31:0] exp);
    {rd_a_addr, rd_b_addr} = {a, ~a};
    @(negedge clk);
    check(rd_a_data, exp);
    {rd_a_addr, rd_b_addr} = {~a, a};
    @(negedge clk);
    check(rd_b_data, exp);
  endtask : gpr_rd

  task automatic acc_wr(input logic [4:0] op, input logic [31:0] d);
    {sum_op, sum_wdata} = {op, d};
    @(negedge clk);
    sum_op = 5'h00;
    @(negedge clk);
  endtask : acc_wr

  task automatic acc_rd(input logic [4:0] op, input logic [31:0] exp);
    sum_op = op;
    @(negedge clk);
    sum_op = 5'h00;
    wait_hi(1);
    check(sum_rdata, exp);
    @(negedge clk);
  endtask : acc_rd

  task automatic t_reset;
    check(status_word & 32'hFFFF3EFF, 32'h00000000);
    ctrl_rd(3'h1, 32'h00000000);
    ctrl_rd(3'h4, 32'h00000000);
  endtask : t_reset

  task automatic t_gpr;
    for (int i = 0; i < 16; i++)
      gpr_wr(4'(i), 32'hA5000000 + i);
    for (int i = 0; i < 16; i++)
      gpr_rd(4'(i), 32'hA5000000 + i);
    {call_en, call_ret_addr} = {1'b1, 32'h00C0FFEE};
    @(negedge clk);
    call_en = 1'b0;
    gpr_rd(4'hE, 32'h00C0FFEE);
  endtask : t_gpr

  task automatic t_stack;
    ctrl_wr(3'h3, 32'h0000BEE0);
    @(negedge clk);
    ctrl_wr(3'h0, 32'h00000080);
    gpr_rd(4'hF, 32'h0000BEE0);
    gpr_wr(4'hF, 32'h00005A50);
    ctrl_rd(3'h3, 32'h00005A50);
    ctrl_rd(3'h2, 32'hA500000F);
  endtask : t_stack

  task automatic t_status;
    ctrl_wr(3'h0, 32'hFFFFFFFF);
    ctrl_rd(3'h0, 32'h0000C1C1);
    ctrl_wr(3'h1, 32'h00000000);
    ctrl_rd(3'h1, 32'h00000001);
    pm_u.issue(2, 32'h00000000);
    check(flag_mirror, 32'h00000000);
    ctrl_wr(3'h0, 32'h000000C1);
    pm_u.issue(3, 32'h00000001);
    check({31'h0, ext_int_take}, 32'h00000001);
    pm_u.issue(0, 32'h80001237);
    check(status_word, 32'h0000C101);
    ctrl_rd(3'h6, 32'h80001236);
    check({31'h0, ext_int_take}, 32'h00000000);
    pm_u.issue(3, 32'h00000000);
    @(negedge clk);
    pm_u.issue(1, 32'h00000000);
    wait_hi(2);
    check(resume_pc, 32'h80001234);
    check(status_word, 32'h0000C1C1);
    ctrl_wr(3'h6, 32'h00000007);
    ctrl_rd(3'h6, 32'h00000006);
  endtask : t_status

  task automatic t_acc;
    acc_wr(5'h10, 32'hAA800001);
    acc_wr(5'h08, 32'h12345678);
    acc_rd(5'h04, 32'hFF800001);
    acc_rd(5'h02, 32'h12345678);
    acc_rd(5'h01, 32'h00011234);
    acc_wr(5'h08, 32'h00000000);
    acc_rd(5'h04, 32'hFF800001);
    {product_op, dsp_load_val} = {1'b1, 56'h123456789ABCDE};
    @(negedge clk);
    product_op = 1'b0;
    acc_rd(5'h02, 32'h789ABCDE);
    acc_rd(5'h04, 32'h00123456);
    {dsp_load_en, dsp_load_val} = {1'b1, 56'hF0000000000001};
    @(negedge clk);
    dsp_load_en = 1'b0;
    acc_rd(5'h04, 32'hFFF00000);
  endtask : t_acc

  // clock enable low: a write pulse must leave the register untouched
  task automatic t_hold;
    ce = 1'b0;
    gpr_wr(4'h3, 32'h0BADF00D);
    ce = 1'b1;
    gpr_rd(4'h3, 32'hA5000003);
  endtask : t_hold

  initial
  begin
    {rstn, wr_en, call_en, write_ctrl_op, read_ctrl_op} = 5'h00;
    ce = 1'b1;
    {dsp_load_en, product_op, sum_op} = 7'h00;
    {rd_a_addr, rd_b_addr, wr_addr, ctrl_num} = 15'h0000;
    {wr_data, call_ret_addr, ctrl_wdata, sum_wdata} = 128'h0;
    dsp_load_val = 56'h00000000000000;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_gpr();
    t_hold();
    t_stack();
    t_status();
    t_acc();
    summarize();
  end
endmodule : crf_core_regs_tb

// file: testbench/crf_exec_model.sv
// model of the execute and exception logic beside the register file
`timescale 1ns/1ps
module crf_exec_model (
  // clock
  input wire logic clk,
  // events toward the register file
  output logic exception_event,
  output logic [31:0] exc_pc,
  output logic return_from_exception,
  output logic external_request,
  output logic flag_we,
  output logic flag_val
);
  initial
  begin
    {exception_event, return_from_exception, external_request} = 3'h0;
    {flag_we, flag_val} = 2'h0;
    exc_pc = 32'h00000000;
  end
  // one event per call, entered at a falling edge; 3 sets the level
  task automatic issue(input int kind, input logic [31:0] v);
    exception_event = (kind == 0);
    exc_pc = v;
    return_from_exception = (kind == 1);
    flag_we = (kind == 2);
    flag_val = v[0];
    if (kind == 3)
      external_request = v[0];
    @(negedge clk);
    {exception_event, return_from_exception, flag_we} = 3'h0;
    // address no longer qualified: show its inverse
    exc_pc = ~v;
    flag_val = ~v[0];
  endtask : issue
endmodule : crf_exec_model

// file: verilog/crf_core_regs.sv
// core register file: general slots, control registers, accumulator
`timescale 1ns/1ps
module crf_core_regs (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // general register reads
  input wire logic [3:0] rd_a_addr,
  input wire logic [3:0] rd_b_addr,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  // general register write
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [31:0] wr_data,
  // subroutine call
  input wire logic call_en,
  input wire logic [31:0] call_ret_addr,
  // control register moves
  input wire logic write_ctrl_op,
  input wire logic read_ctrl_op,
  input wire logic [2:0] ctrl_num,
  input wire logic [31:0] ctrl_wdata,
  output logic [31:0] ctrl_rdata,
  output logic ctrl_rvalid,
  // condition flag from the execute stage
  input wire logic flag_we,
  input wire logic flag_val,
  // exception entry and return
  input wire logic exception_event,
  input wire logic [31:0] exc_pc,
  input wire logic return_from_exception,
  output logic [31:0] resume_pc,
  output logic resume_valid,
  // interrupt gating
  input wire logic external_request,
  output logic ext_int_take,
  // accumulator moves
  input wire crf_pkg::crf_sum_op_t sum_op,
  input wire logic [31:0] sum_wdata,
  output logic [31:0] sum_rdata,
  output logic sum_rvalid,
  // accumulator load from dsp datapath and multiply scratch
  input wire logic dsp_load_en,
  input wire logic product_op,
  input wire logic [55:0] dsp_load_val,
  // status
  output crf_pkg::crf_status_t status_word,
  output logic [31:0] flag_mirror
);

  crf_pkg::crf_status_t status_q;
  crf_pkg::crf_status_t status_d;
  logic [31:0] bpc_q;
  logic [55:0] sum_q;
  logic [55:0] sum_d;
  logic [31:0] sum_rdata_q;
  logic sum_rvalid_q;
  logic [31:0] ctrl_local_q;
  logic ctrl_pend_q;
  logic ctrl_sp_q;
  logic [31:0] ctrl_rdata_q;
  logic ctrl_rvalid_q;
  logic [31:0] resume_pc_q;
  logic resume_valid_q;
  logic ext_int_take_q;
  logic [31:0] mem_qc;

  // decode
  wire logic psel = status_q.pointer_select;
  wire logic is_cr_status = (ctrl_num == crf_pkg::CRF_CR_STATUS);
  wire logic is_cr_mirror = (ctrl_num == crf_pkg::CRF_CR_MIRROR);
  wire logic is_cr_isp = (ctrl_num == crf_pkg::CRF_CR_ISP);
  wire logic is_cr_usp = (ctrl_num == crf_pkg::CRF_CR_USP);
  wire logic is_cr_bpc = (ctrl_num == crf_pkg::CRF_CR_BPC);
  wire logic is_cr_sp = is_cr_isp || is_cr_usp;

  // register fifteen follows the select bit as it stands now
  wire logic [4:0] phys_a = crf_pkg::crf_phys(rd_a_addr, psel);
  wire logic [4:0] phys_b = crf_pkg::crf_phys(rd_b_addr, psel);
  wire logic [4:0] phys_w = crf_pkg::crf_phys(wr_addr, psel);

  // stack pointers as control registers, independent of select
  wire logic [4:0] phys_cr = is_cr_usp ? crf_pkg::CRF_PHYS_USP
                                       : crf_pkg::CRF_PHYS_ISP;

  // one write port: general write, then call link, then control move
  wire logic ctrl_sp_wr = write_ctrl_op && is_cr_sp;
  wire logic mem_we = wr_en || call_en || ctrl_sp_wr;
  wire logic [4:0] mem_waddr = wr_en ? phys_w
                             : call_en ? crf_pkg::CRF_PHYS_LINK
                             : phys_cr;
  wire logic [31:0] mem_wdata = wr_en ? wr_data
                              : call_en ? call_ret_addr
                              : ctrl_wdata;

  // control write to the status word keeps reserved bits at zero
  wire logic [31:0] status_wr_val =
    ctrl_wdata & crf_pkg::CRF_STATUS_WMASK;

  // flag mirror: only the lowest bit, all else zero
  wire logic [31:0] mirror_val =
    {crf_pkg::CRF_ZERO_W[31:1], status_q.flag};

  // local value of a control read
  wire logic [31:0] ctrl_local_val =
    is_cr_status ? status_q
    : is_cr_mirror ? mirror_val
    : is_cr_bpc ? bpc_q
    : crf_pkg::CRF_ZERO_W;

  // backup counter: lsb-first bit 0 is doc bit 31, kept zero
  wire logic [31:0] bpc_from_exc = {exc_pc[31:1], 1'b0};
  wire logic [31:0] bpc_from_ctrl = {ctrl_wdata[31:1], 1'b0};

  // accumulator 64-bit view and the three slices
  wire logic [63:0] sum_view = crf_pkg::crf_view(sum_q);
  wire logic [31:0] sum_hi_val = sum_view[63:32];
  wire logic [31:0] sum_lo_val = sum_view[31:0];
  wire logic [31:0] sum_mid_val = sum_view[47:16];
  wire logic sum_rd = sum_op.sum_read_upper || sum_op.sum_read_lower
                      || sum_op.sum_read_middle;
  wire logic [31:0] sum_rd_val = sum_op.sum_read_upper ? sum_hi_val
                               : sum_op.sum_read_lower ? sum_lo_val
                               : sum_mid_val;

  // next status value
  always_comb
  begin
    status_d = status_q;
    if (exception_event)
    begin
      status_d.saved_pointer_select = status_q.pointer_select;
      status_d.saved_int_gate = status_q.interrupt_gate;
      status_d.saved_flag = status_q.flag;
      status_d.pointer_select = 1'b0;
      status_d.interrupt_gate = 1'b0;
    end
    else if (return_from_exception)
    begin
      status_d.pointer_select = status_q.saved_pointer_select;
      status_d.interrupt_gate = status_q.saved_int_gate;
      status_d.flag = status_q.saved_flag;
    end
    else if (write_ctrl_op && is_cr_status)
    begin
      status_d = crf_pkg::crf_status_t'(status_wr_val);
    end
    else if (flag_we)
    begin
      status_d.flag = flag_val;
    end
  end

  // next accumulator value
  always_comb
  begin
    sum_d = sum_q;
    if (product_op || dsp_load_en)
    begin
      sum_d = dsp_load_val;
    end
    else if (sum_op.sum_write_upper)
    begin
      sum_d[55:32] = sum_wdata[23:0];
    end
    else if (sum_op.sum_write_lower)
    begin
      sum_d[31:0] = sum_wdata;
    end
  end

  // general registers and stack pointers
  crf_mem u_mem (
    .clk(clk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .ra(phys_a),
    .rb(phys_b),
    .rc(phys_cr),
    .qa(rd_a_data),
    .qb(rd_b_data),
    .qc(mem_qc)
  );

  // status fields under reset, backups left alone
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      status_q.rsv_hi <= '0;
      status_q.rsv_mid <= '0;
      status_q.rsv_lo <= '0;
      status_q.pointer_select <= 1'b0;
      status_q.interrupt_gate <= 1'b0;
      status_q.flag <= 1'b0;
    end
    else if (ce)
    begin
      status_q.rsv_hi <= status_d.rsv_hi;
      status_q.rsv_mid <= status_d.rsv_mid;
      status_q.rsv_lo <= status_d.rsv_lo;
      status_q.pointer_select <= status_d.pointer_select;
      status_q.interrupt_gate <= status_d.interrupt_gate;
      status_q.flag <= status_d.flag;
    end
  end

  // backup bits take no reset value
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      status_q.saved_pointer_select <= status_d.saved_pointer_select;
      status_q.saved_int_gate <= status_d.saved_int_gate;
      status_q.saved_flag <= status_d.saved_flag;
    end
  end

  // backup counter and accumulator: no reset
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (exception_event)
      begin
        bpc_q <= bpc_from_exc;
      end
      else if (write_ctrl_op && is_cr_bpc)
      begin
        bpc_q <= bpc_from_ctrl;
      end
      sum_q <= sum_d;
    end
  end

  // return resumes at a word address
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      resume_pc_q <= crf_pkg::CRF_ZERO_W;
      resume_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      resume_valid_q <= return_from_exception && !exception_event;
      if (return_from_exception && !exception_event)
      begin
        resume_pc_q <= {bpc_q[31:2], crf_pkg::CRF_RESUME_LOW};
      end
    end
  end

  // only external requests are gated
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ext_int_take_q <= 1'b0;
    end
    else if (ce)
    begin
      ext_int_take_q <= external_request && status_q.interrupt_gate;
    end
  end

  // control read, first stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_pend_q <= 1'b0;
      ctrl_sp_q <= 1'b0;
      ctrl_local_q <= crf_pkg::CRF_ZERO_W;
    end
    else if (ce)
    begin
      ctrl_pend_q <= read_ctrl_op;
      ctrl_sp_q <= is_cr_sp;
      ctrl_local_q <= ctrl_local_val;
    end
  end

  // control read, second stage
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ctrl_rvalid_q <= 1'b0;
      ctrl_rdata_q <= crf_pkg::CRF_ZERO_W;
    end
    else if (ce)
    begin
      ctrl_rvalid_q <= ctrl_pend_q;
      if (ctrl_pend_q)
      begin
        ctrl_rdata_q <= ctrl_sp_q ? mem_qc : ctrl_local_q;
      end
    end
  end

  // accumulator read moves
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sum_rvalid_q <= 1'b0;
      sum_rdata_q <= crf_pkg::CRF_ZERO_W;
    end
    else if (ce)
    begin
      sum_rvalid_q <= sum_rd;
      if (sum_rd)
      begin
        sum_rdata_q <= sum_rd_val;
      end
    end
  end

  assign status_word = status_q;
  assign flag_mirror = mirror_val;
  assign ctrl_rdata = ctrl_rdata_q;
  assign ctrl_rvalid = ctrl_rvalid_q;
  assign resume_pc = resume_pc_q;
  assign resume_valid = resume_valid_q;
  assign ext_int_take = ext_int_take_q;
  assign sum_rdata = sum_rdata_q;
  assign sum_rvalid = sum_rvalid_q;

endmodule : crf_core_regs

// file: verilog/crf_mem.sv
// storage for general registers and both stack pointers
`timescale 1ns/1ps
module crf_mem (
  // clocking
  input wire logic clk,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [31:0] wdata,
  // read ports
  input wire logic [4:0] ra,
  input wire logic [4:0] rb,
  input wire logic [4:0] rc,
  output logic [31:0] qa,
  output logic [31:0] qb,
  output logic [31:0] qc
);

  logic [31:0] mem_q [crf_pkg::CRF_MEM_DEPTH];

  // no reset: contents start unknown
  always_ff @(posedge clk)
  begin
    if (ce && we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  // reads give the value before a same-cycle write
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      qa <= mem_q[ra];
      qb <= mem_q[rb];
      qc <= mem_q[rc];
    end
  end

endmodule : crf_mem

// file: verilog/crf_pkg.sv
// constants, types and helpers shared by the core register file
package crf_pkg;

  localparam int CRF_W = 32;
  localparam int CRF_NUM_GPR = 16;
  localparam int CRF_MEM_DEPTH = 17;
  localparam int CRF_MEM_AW = 5;
  localparam int CRF_ACC_W = 56;
  localparam int CRF_VIEW_W = 64;

  localparam logic [3:0] CRF_LINK_SLOT = 4'hE;
  localparam logic [3:0] CRF_STACK_SLOT = 4'hF;
  localparam logic [4:0] CRF_PHYS_LINK = 5'h0E;
  localparam logic [4:0] CRF_PHYS_ISP = 5'h0F;
  localparam logic [4:0] CRF_PHYS_USP = 5'h10;

  // writable status bits: backups, select, gate, flag (lsb-first index)
  localparam logic [31:0] CRF_STATUS_WMASK = 32'h0000C1C1;
  localparam logic [31:0] CRF_MIRROR_RST = 32'h00000000;
  localparam logic [31:0] CRF_ZERO_W = 32'h00000000;
  localparam logic [1:0] CRF_RESUME_LOW = 2'h0;

  // control register numbers
  typedef enum logic [2:0] {
    CRF_CR_STATUS = 3'h0,
    CRF_CR_MIRROR = 3'h1,
    CRF_CR_ISP = 3'h2,
    CRF_CR_USP = 3'h3,
    CRF_CR_BPC = 3'h6
  } crf_ctrl_t;

  // status word, most significant field first; bit 0 of the doc is the msb
  typedef struct packed {
    logic [15:0] rsv_hi;
    logic saved_pointer_select;
    logic saved_int_gate;
    logic [4:0] rsv_mid;
    logic saved_flag;
    logic pointer_select;
    logic interrupt_gate;
    logic [4:0] rsv_lo;
    logic flag;
  } crf_status_t;

  // one accumulator move request
  typedef struct packed {
    logic sum_write_upper;
    logic sum_write_lower;
    logic sum_read_upper;
    logic sum_read_lower;
    logic sum_read_middle;
  } crf_sum_op_t;

  // stack slot follows the select bit
  function automatic logic [4:0] crf_phys(input logic [3:0] idx,
                                          input logic psel);
    crf_phys = {1'b0, idx};
    if (idx == CRF_STACK_SLOT)
    begin
      crf_phys = psel ? CRF_PHYS_USP : CRF_PHYS_ISP;
    end
  endfunction : crf_phys

  // 64-bit view: top byte repeats the highest stored bit
  function automatic logic [63:0] crf_view(input logic [55:0] acc);
    crf_view = {{8{acc[55]}}, acc};
  endfunction : crf_view

endpackage : crf_pkg
